// ---- encoder_trigger_fifo_status.v ----
// Four-channel encoder counters with triggers, preset command and acquisition FIFO status.
// Notes on behaviour
// [R1] Four channels, each own enables, counter, preset.
// [R2] Rollunder trigger from zero to N-1, readable.
// [R3] Zero trigger only while zero enable set.
// [R4] Register 0x26 bit 9 shows FIFO empty.
// [R5] Register 0x26 bit 8 shows FIFO full.
// [R6] Full FIFO accepts no records until space.
// [R7] Event stalled by full waits for host clear.
// [R8] Preset command loads only addressed channel.
// [R9] Version readable anytime without side effect.
// [R10] Module address stored and readable.
// [R11] Host reassigns duplicate module addresses.
// [R12] Host reloads logic and restores settings.
// [R13] Rollover trigger from N-1 to zero.
// [R14] One pulse per qualifying counter transition.
`timescale 1ns/1ps
`include "enc_trig_map.vh"
module encoder_trigger_fifo_status (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire [5:0]  regAddr,
  input  wire        regWr,
  input  wire        regRd,
  input  wire [31:0] regWrData,
  output reg  [31:0] regRdData,
  input  wire [3:0]  countUp,
  input  wire [3:0]  countDown,
  output reg  [3:0]  trigPulse,
  output wire        fifoEmpty,
  output wire        fifoFull,
  output wire        eventStalled
);
  // ==========================================================
  // Channel registers and counters
  reg  [7:0]  ctrl_reg    [0:3];
  reg  [31:0] preset_reg  [0:3];
  reg  [31:0] modulus_reg [0:3];
  reg  [31:0] count_reg   [0:3];
  reg  [7:0]  modAddr_reg;
  wire [3:0]  chanTrig;
  wire        presetCmd = clkEn & regWr & (regAddr == `REG_CMD) & regWrData[`CMD_PRESET_EN];
  wire [1:0]  presetCh  = regWrData[`CMD_CH_MSB:`CMD_CH_LSB];

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : chan
      wire [31:0] cnt = count_reg[ch];
      wire [31:0] top = modulus_reg[ch] - 32'h00000001;
      wire        modN = ctrl_reg[ch][`CTRL_MODN];
      wire        up = countUp[ch] & ~countDown[ch];
      wire        dn = countDown[ch] & ~countUp[ch];
      wire        rUnder = dn & modN & (cnt == `ZERO32);
      wire        rOver = up & modN & (cnt == top);
      reg  [31:0] nextCnt;
      always @* begin
        nextCnt = cnt;
        if (presetCmd && presetCh == ch) begin
          nextCnt = preset_reg[ch]; // [R8]
        end else if (rUnder) begin
          nextCnt = top;
        end else if (rOver) begin
          nextCnt = `ZERO32;
        end else if (up) begin
          nextCnt = cnt + 32'h00000001;
        end else if (dn) begin
          nextCnt = cnt - 32'h00000001;
        end
      end
      wire changed = (nextCnt != cnt);
      assign chanTrig[ch] =
        (ctrl_reg[ch][`CTRL_RUNDER_EN] & rUnder) | // [R2]
        (ctrl_reg[ch][`CTRL_ROVER_EN] & rOver) | // [R13]
        (ctrl_reg[ch][`CTRL_ZERO_EN] & changed & (nextCnt == `ZERO32)); // [R3] [R14]
      always @(posedge core_clk) begin
        if (!rst_n) begin
          count_reg[ch] <= `ZERO32;
          ctrl_reg[ch] <= 8'h00;
          preset_reg[ch] <= `ZERO32;
          modulus_reg[ch] <= `ZERO32;
        end else if (clkEn) begin
          count_reg[ch] <= nextCnt; // [R1]
          if (regWr && regAddr == `REG_CTRL0 + ch) begin
            ctrl_reg[ch] <= regWrData[7:0];
          end
          if (regWr && regAddr == `REG_PRESET0 + ch) begin
            preset_reg[ch] <= regWrData;
          end
          if (regWr && regAddr == `REG_MODULUS0 + ch) begin
            modulus_reg[ch] <= regWrData;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Acquisition FIFO
  reg  [`FIFO_CW-1:0] level_reg;
  reg  [`FIFO_AW-1:0] wrPtr_reg;
  reg  [`FIFO_AW-1:0] rdPtr_reg;
  reg                 stall_reg;
  wire [`REC_W-1:0]   memRd;
  wire [3:0]          evtEn;
  assign evtEn = {ctrl_reg[3][`CTRL_EVENT_EN], ctrl_reg[2][`CTRL_EVENT_EN],
                  ctrl_reg[1][`CTRL_EVENT_EN], ctrl_reg[0][`CTRL_EVENT_EN]};
  assign fifoEmpty = (level_reg == {`FIFO_CW{1'b0}});
  assign fifoFull  = (level_reg == `FIFO_DEPTH);
  assign eventStalled = stall_reg;
  wire fifoClr  = regWr & (regAddr == `REG_FIFO_STAT) & regWrData[`BIT_FIFO_CLEAR];
  wire evtClr   = regWr & (regAddr == `REG_FIFO_STAT) & regWrData[`BIT_EVENT_CLEAR];
  wire timeReq  = regWr & (regAddr == `REG_CMD) & regWrData[`CMD_SAMPLE];
  wire evtReq   = |(chanTrig & evtEn);
  wire capReq   = timeReq | (evtReq & ~stall_reg); // [R7]
  wire doRead   = regRd & (regAddr == `REG_FIFO_STAT) & ~fifoEmpty;
  wire doWrite  = capReq & ~fifoFull & ~fifoClr; // [R6]
  wire [`REC_W-1:0] record = {count_reg[3][7:0], count_reg[2][7:0],
                              count_reg[1][7:0], count_reg[0][7:0]};

  rec_mem u_mem (
    .clk    (core_clk),
    .ce     (clkEn),
    .wrEn   (doWrite),
    .wrAddr (wrPtr_reg),
    .wrData (record),
    .rdAddr (rdPtr_reg),
    .rdData (memRd)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      level_reg <= {`FIFO_CW{1'b0}};
      wrPtr_reg <= {`FIFO_AW{1'b0}};
      rdPtr_reg <= {`FIFO_AW{1'b0}};
      stall_reg <= 1'b0;
      modAddr_reg <= `MODADDR_RESET;
    end else if (clkEn) begin
      if (fifoClr) begin
        level_reg <= {`FIFO_CW{1'b0}};
        wrPtr_reg <= {`FIFO_AW{1'b0}};
        rdPtr_reg <= {`FIFO_AW{1'b0}};
      end else begin
        if (doWrite) begin
          wrPtr_reg <= wrPtr_reg + 4'h1;
        end
        if (doRead) begin
          rdPtr_reg <= rdPtr_reg + 4'h1;
        end
        if (doWrite && !doRead) begin
          level_reg <= level_reg + 5'h01;
        end else if (doRead && !doWrite) begin
          level_reg <= level_reg - 5'h01;
        end
      end
      if (evtReq && fifoFull && !stall_reg) begin
        stall_reg <= 1'b1; // [R7]
      end else if (evtClr) begin
        stall_reg <= 1'b0;
      end
      if (regWr && regAddr == `REG_MODADDR) begin
        modAddr_reg <= regWrData[7:0]; // [R10]
      end
    end
  end

  // ==========================================================
  // Register read port
  reg [31:0] rdMux;
  always @* begin
    rdMux = `ZERO32;
    case (regAddr)
      `REG_CTRL0:   rdMux = {24'h000000, ctrl_reg[0]}; // [R2]
      `REG_CTRL1:   rdMux = {24'h000000, ctrl_reg[1]};
      `REG_CTRL2:   rdMux = {24'h000000, ctrl_reg[2]};
      `REG_CTRL3:   rdMux = {24'h000000, ctrl_reg[3]};
      `REG_PRESET0: rdMux = preset_reg[0];
      `REG_PRESET1: rdMux = preset_reg[1];
      `REG_PRESET2: rdMux = preset_reg[2];
      `REG_PRESET3: rdMux = preset_reg[3];
      `REG_MODULUS0: rdMux = modulus_reg[0];
      `REG_MODULUS1: rdMux = modulus_reg[1];
      `REG_MODULUS2: rdMux = modulus_reg[2];
      `REG_MODULUS3: rdMux = modulus_reg[3];
      `REG_COUNT0:  rdMux = count_reg[0];
      `REG_COUNT1:  rdMux = count_reg[1];
      `REG_COUNT2:  rdMux = count_reg[2];
      `REG_COUNT3:  rdMux = count_reg[3];
      `REG_VERSION: rdMux = {16'h0000, `VERSION_VALUE}; // [R9]
      `REG_MODADDR: rdMux = {24'h000000, modAddr_reg}; // [R10]
      `REG_FIFO_PEEK: rdMux = memRd;
      `REG_FIFO_STAT: begin
        rdMux[`BIT_FIFO_EMPTY] = fifoEmpty; // [R4]
        rdMux[`BIT_FIFO_FULL]  = fifoFull; // [R5]
        rdMux[`BIT_EVENT_CLEAR] = stall_reg;
      end
      default:      rdMux = `ZERO32;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= `ZERO32;
      trigPulse <= 4'h0;
    end else if (clkEn) begin
      if (regRd) begin
        regRdData <= rdMux;
      end
      trigPulse <= chanTrig; // [R14]
    end
  end
endmodule

// ---- enc_trig_map.vh ----
// Register offsets, field positions and constants of the encoder trigger block.
`ifndef ENC_TRIG_MAP_VH
`define ENC_TRIG_MAP_VH
`define REG_CTRL0        6'h00
`define REG_CTRL1        6'h01
`define REG_CTRL2        6'h02
`define REG_CTRL3        6'h03
`define REG_PRESET0      6'h04
`define REG_PRESET1      6'h05
`define REG_PRESET2      6'h06
`define REG_PRESET3      6'h07
`define REG_MODULUS0     6'h08
`define REG_MODULUS1     6'h09
`define REG_MODULUS2     6'h0a
`define REG_MODULUS3     6'h0b
`define REG_COUNT0       6'h0c
`define REG_COUNT1       6'h0d
`define REG_COUNT2       6'h0e
`define REG_COUNT3       6'h0f
`define REG_CMD          6'h10
`define REG_VERSION      6'h11
`define REG_MODADDR      6'h12
`define REG_FIFO_PEEK    6'h13
`define REG_FIFO_STAT    6'h26
`define BIT_FIFO_EMPTY   9
`define BIT_FIFO_FULL    8
`define BIT_FIFO_CLEAR   0
`define BIT_EVENT_CLEAR  1
`define CTRL_ZERO_EN     0
`define CTRL_RUNDER_EN   1
`define CTRL_ROVER_EN    2
`define CTRL_MODN        3
`define CTRL_EVENT_EN    4
`define CMD_PRESET_EN    2
`define CMD_CH_LSB       0
`define CMD_CH_MSB       1
`define CMD_SAMPLE       3
`define VERSION_VALUE    16'h0001
`define MODADDR_RESET    8'h00
`define FIFO_DEPTH       16
`define FIFO_AW          4
`define FIFO_CW          5
`define REC_W            32
`define ZERO32           32'h00000000
`endif

// ---- rec_mem.v ----
// Record memory of the acquisition FIFO with registered read data.
`timescale 1ns/1ps
`include "enc_trig_map.vh"
module rec_mem (
  input  wire                clk,
  input  wire                ce,
  input  wire                wrEn,
  input  wire [`FIFO_AW-1:0] wrAddr,
  input  wire [`REC_W-1:0]   wrData,
  input  wire [`FIFO_AW-1:0] rdAddr,
  output reg  [`REC_W-1:0]   rdData
);
  reg [`REC_W-1:0] mem [0:`FIFO_DEPTH-1];
  always @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ---- enc_trig_props.sv ----
// Checker of the encoder trigger block ports.
`timescale 1ns/1ps
`include "enc_trig_map.vh"
module enc_trig_props (
  input wire        core_clk,
  input wire        rst_n,
  input wire        clkEn,
  input wire [5:0]  regAddr,
  input wire        regWr,
  input wire        regRd,
  input wire [31:0] regWrData,
  input wire [31:0] regRdData,
  input wire [3:0]  countUp,
  input wire [3:0]  countDown,
  input wire [3:0]  trigPulse,
  input wire        fifoEmpty,
  input wire        fifoFull,
  input wire        eventStalled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire rdStat = clkEn && regRd && regAddr == `REG_FIFO_STAT;
  wire wrStat = clkEn && regWr && regAddr == `REG_FIFO_STAT;
  wire cause  = |(countUp ^ countDown) || (regWr && regAddr == `REG_CMD);
  property p_excl; !(fifoEmpty && fifoFull); endproperty
  a_excl: assert property (p_excl) else $error("empty and full together");
  property p_stat; rdStat |=> regRdData[9:8] == $past({fifoEmpty, fifoFull}); endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_full; fifoFull && !rdStat && !(wrStat && regWrData[0]) |=> fifoFull; endproperty
  a_full: assert property (p_full) else $error("full dropped");
  property p_clr; wrStat && regWrData[0] |=> fifoEmpty; endproperty
  a_clr: assert property (p_clr) else $error("clear left records");
  property p_stall; eventStalled && !(wrStat && regWrData[1]) |=> eventStalled; endproperty
  a_stall: assert property (p_stall) else $error("stall dropped");
  property p_ver;
    clkEn && regRd && regAddr == `REG_VERSION |=> regRdData[15:0] == `VERSION_VALUE;
  endproperty
  a_ver: assert property (p_ver) else $error("version wrong");
  property p_cause; $past(clkEn) && |trigPulse |-> $past(cause); endproperty
  a_cause: assert property (p_cause) else $error("trigger without step");
  property p_hold; !(clkEn && regRd) |=> $stable(regRdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_frz;
    !clkEn |=> $stable(trigPulse) && $stable(eventStalled) && $stable(fifoEmpty) &&
               $stable(regRdData);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule
bind encoder_trigger_fifo_status enc_trig_props u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .clkEn(clkEn), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
  .regRdData(regRdData), .countUp(countUp), .countDown(countDown), .trigPulse(trigPulse),
  .fifoEmpty(fifoEmpty), .fifoFull(fifoFull), .eventStalled(eventStalled));

// ---- enc_host.sv ----
// Host model that reaches the block registers.
`timescale 1ns/1ps
`include "enc_trig_map.vh"
module enc_host (
  input  wire         core_clk,
  input  wire  [31:0] regRdData,
  output logic        clkEn,
  output logic [5:0]  regAddr,
  output logic        regWr,
  output logic        regRd,
  output logic [31:0] regWrData
);
  logic [7:0] savedCtrl [0:3];
  initial begin
    {clkEn, regAddr, regWr, regRd, regWrData} = {1'h1, 40'h0};
    for (int c = 0; c < 4; c++) begin
      savedCtrl[c] = 8'h00;
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'h1;
    @(negedge core_clk);
    regWr = 1'h0;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    @(negedge core_clk);
    regAddr = a;
    regRd = 1'h1;
    @(negedge core_clk);
    regRd = 1'h0;
    q = regRdData;
  endtask
  task automatic hold(input logic v);
    @(negedge core_clk);
    clkEn = v;
  endtask
  // Reads the module address and moves it on when another unit already holds it.
  task automatic claim(input logic [7:0] seen, output logic [7:0] got);
    logic [31:0] v;
    rd(`REG_MODADDR, v);
    got = v[7:0];
    if (got == seen) begin
      got = seen + 8'h01;
      wr(`REG_MODADDR, {24'h000000, got});
    end
  endtask
  task automatic keep(input int c, input logic [7:0] v);
    savedCtrl[c] = v;
    wr(6'(`REG_CTRL0 + c), {24'h000000, v});
  endtask
  // Puts back the saved control settings that a restarted unit has lost.
  task automatic restore;
    logic [31:0] v;
    for (int c = 0; c < 4; c++) begin
      rd(6'(`REG_CTRL0 + c), v);
      if (v[7:0] !== savedCtrl[c]) begin
        wr(6'(`REG_CTRL0 + c), {24'h000000, savedCtrl[c]});
      end
    end
  endtask
endmodule

// ---- encoder_trigger_fifo_status_test.sv ----
// Self-checking testbench of the encoder trigger block.
`timescale 1ns/1ps
`include "enc_trig_map.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module encoder_trigger_fifo_status_test;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic [3:0]  countUp = 0;
  logic [3:0]  countDown = 0;
  wire  [31:0] regWrData, regRdData;
  wire  [5:0]  regAddr;
  wire  [3:0]  trigPulse;
  wire         clkEn, regWr, regRd, fifoEmpty, fifoFull, eventStalled;
  logic [31:0] q;
  int          n, n_fail = 0, n_tests = 0;
  always #4 core_clk = ~core_clk;
  enc_host host (.core_clk(core_clk), .regRdData(regRdData), .clkEn(clkEn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData));
  encoder_trigger_fifo_status dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData(regRdData), .countUp(countUp), .countDown(countDown), .trigPulse(trigPulse),
    .fifoEmpty(fifoEmpty), .fifoFull(fifoFull), .eventStalled(eventStalled));
  task automatic step(input int c, input bit up);
    n = 0;
    @(negedge core_clk);
    countUp[c] = up;
    countDown[c] = !up;
    repeat (3) begin
      @(negedge core_clk);
      countUp = 4'h0;
      countDown = 4'h0;
      n += (trigPulse[c] === 1'h1);
    end
  endtask
  task automatic t_regs;
    host.rd(`REG_FIFO_STAT, q);
    `CHK("stat", 2'h2, q[9:8])
    host.rd(`REG_MODADDR, q);
    `CHK("addr rst", 8'h00, q[7:0])
    host.wr(`REG_MODADDR, 32'h5a);
    host.rd(`REG_MODADDR, q);
    `CHK("addr", 8'h5a, q[7:0])
    host.rd(`REG_VERSION, q);
    host.rd(`REG_VERSION, q);
    `CHK("version", `VERSION_VALUE, q[15:0])
  endtask
  task automatic t_trig;
    host.wr(`REG_CTRL0, 32'h1);
    host.wr(`REG_PRESET0, 32'h1);
    host.wr(`REG_CMD, 32'h4);
    step(0, 0);
    `CHK("zero", 1, n)
    host.wr(`REG_CTRL0, 32'h0);
    step(0, 1);
    step(0, 0);
    `CHK("zero off", 0, n)
    host.wr(`REG_MODULUS1, 32'h5);
    host.wr(`REG_CTRL1, 32'he);
    host.rd(`REG_CTRL1, q);
    `CHK("enable", 1'h1, q[1])
    step(1, 0);
    `CHK("under", 1, n)
    host.rd(`REG_COUNT1, q);
    `CHK("n-1", 8'h4, q[7:0])
    step(1, 1);
    `CHK("over", 1, n)
    host.wr(`REG_PRESET3, 32'h3);
    host.wr(`REG_PRESET2, 32'h7);
    host.wr(`REG_CMD, 32'h6);
    host.rd(`REG_COUNT2, q);
    `CHK("preset", 8'h7, q[7:0])
    host.rd(`REG_COUNT3, q);
    `CHK("other", 8'h0, q[7:0])
  endtask
  task automatic t_freeze;
    host.hold(1'h0);
    step(1, 0);
    `CHK("frozen trig", 0, n)
    host.hold(1'h1);
    host.rd(`REG_COUNT1, q);
    `CHK("frozen count", 8'h0, q[7:0])
  endtask
  task automatic t_fifo;
    repeat (`FIFO_DEPTH) host.wr(`REG_CMD, 32'h8);
    `CHK("full", 1'h1, fifoFull)
    host.rd(`REG_FIFO_PEEK, q);
    `CHK("head record", 32'h00070000, q)
    host.wr(`REG_CTRL0, 32'h11);
    host.wr(`REG_CMD, 32'h4);
    step(0, 0);
    `CHK("stall", 1'h1, eventStalled)
    host.wr(`REG_CMD, 32'h8);
    host.rd(`REG_FIFO_STAT, q);
    `CHK("stat", 2'h1, q[9:8])
    `CHK("stall kept", 1'h1, eventStalled)
    repeat (`FIFO_DEPTH - 2) host.rd(`REG_FIFO_STAT, q);
    `CHK("last", 1'h0, fifoEmpty)
    host.rd(`REG_FIFO_STAT, q);
    `CHK("drained", 1'h1, fifoEmpty)
    host.wr(`REG_CMD, 32'h4);
    step(0, 0);
    `CHK("refused", 1'h1, fifoEmpty)
    host.wr(`REG_FIFO_STAT, 32'h2);
    `CHK("unstall", 1'h0, eventStalled)
    host.wr(`REG_CMD, 32'h4);
    step(0, 0);
    `CHK("captured", 1'h0, fifoEmpty)
    host.wr(`REG_CMD, 32'h8);
    host.wr(`REG_FIFO_STAT, 32'h1);
    `CHK("cleared", 1'h1, fifoEmpty)
  endtask
  task automatic t_init;
    logic [7:0] a;
    host.keep(2, 8'h0d);
    @(negedge core_clk);
    rst_n = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    host.rd(`REG_COUNT2, q);
    `CHK("count rst", 32'h0, q)
    host.claim(8'h00, a);
    `CHK("addr claim", 8'h01, a)
    host.rd(`REG_MODADDR, q);
    `CHK("addr moved", 8'h01, q[7:0])
    host.restore;
    host.rd(`REG_CTRL2, q);
    `CHK("restored", 8'h0d, q[7:0])
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1;
    t_regs;
    t_trig;
    t_freeze;
    t_fifo;
    t_init;
    end_of_test;
  end
  initial begin
    #32000;
    n_fail++;
    end_of_test;
  end
endmodule
